// ### src/scl_cfg_ctrl.sv
// Top: reset, load, initialization, user mode and error recovery control
module scl_cfg_ctrl
   import scl_pkg::*;
#(
   parameter int   ERR_HOLD_CYCLES = ERR_HOLD_CYC,
   parameter int   N_BYTES         = FRAME_BYTES,
   parameter logic AUTO_RST_DEF    = 1'b0
) (
   input  wire logic clk_i,
   input  wire logic sys_rst_i,
   input  wire logic shift_clk_i,
   input  wire logic serial_config_data_i,
   input  wire logic cfg_req_n_i,
   input  wire logic status_n_i,
   output logic      status_n_o,
   output logic      status_n_oe_o,
   input  wire logic conf_done_i,
   output logic      conf_done_o,
   output logic      conf_done_oe_o,
   output logic      init_done_o,
   output logic      init_done_oe_o,
   input  wire logic user_clk_i,
   output logic      io_hiz_o,
   output logic      io_pullup_o,
   output logic      user_mode_o
);
   localparam int EW = $clog2(ERR_HOLD_CYCLES + 1);
   localparam int IW = $clog2(N_BYTES + 1);
   localparam logic [EW-1:0] ERR_LAST  = EW'(ERR_HOLD_CYCLES - 1);
   localparam logic [IW-1:0] BYTE_LAST = IW'(N_BYTES - 1);
   localparam logic [8:0]    INIT_LAST = 9'(INIT_CYCLES - 1);
   localparam logic [4:0]    OSC_LAST  = 5'(OSC_DIV - 1);

   scl_state_t    state;
   scl_state_t    next_state;
   scl_link_if    link ();

   logic          req_s;
   logic          status_s;
   logic          done_s;
   logic          usr_s;
   logic          usr_prev;
   logic          tgl_s;
   logic          tgl_last;
   logic          byte_evt;
   logic [IW-1:0] byte_idx;
   logic [7:0]    chk;
   logic          chk_ok;
   logic          opt_init_done;
   logic          opt_user_clk;
   logic          opt_auto_rst;
   logic [4:0]    div_cnt;
   logic          osc_tick;
   logic          usr_tick;
   logic          init_tick;
   logic [8:0]    init_cnt;
   logic [EW-1:0] err_cnt;
   logic          drive_low;

   // Serial receiver on the shift clock
   scl_link_rx u_rx (
      .shift_clk_i          (shift_clk_i),
      .sys_rst_i            (sys_rst_i),
      .serial_config_data_i (serial_config_data_i),
      .link                 (link)
   );

   // Pin and cross-domain synchronisers
   scl_sync #(.INIT(1'b0)) u_req_sync (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .async_i   (cfg_req_n_i),
      .sync_o    (req_s)
   );
   scl_sync #(.INIT(1'b0)) u_status_sync (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .async_i   (status_n_i),
      .sync_o    (status_s)
   );
   scl_sync #(.INIT(1'b0)) u_done_sync (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .async_i   (conf_done_i),
      .sync_o    (done_s)
   );
   scl_sync #(.INIT(1'b0)) u_usr_sync (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .async_i   (user_clk_i),
      .sync_o    (usr_s)
   );
   scl_sync #(.INIT(1'b0)) u_tgl_sync (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .async_i   (link.byte_tgl),
      .sync_o    (tgl_s)
   );

   // Byte arrival; bytes landing outside loading are absorbed
   assign byte_evt = (state == ST_LOAD) && (tgl_s != tgl_last);
   assign chk_ok   = (chk == link.byte_data);

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         tgl_last <= 1'b0;
      end else begin
         tgl_last <= tgl_s;
      end
   end

   // Initialization tick: oscillator divider or user start-up clock edge
   assign osc_tick  = (div_cnt == OSC_LAST);
   assign usr_tick  = usr_s && !usr_prev;
   assign init_tick = opt_user_clk ? usr_tick : osc_tick;

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         usr_prev <= 1'b0;
      end else begin
         usr_prev <= usr_s;
      end
   end

   // Internal oscillator runs only during initialization
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || state != ST_INIT || osc_tick) begin
         div_cnt <= 5'h00;
      end else begin
         div_cnt <= div_cnt + 5'h01;
      end
   end

   // Initialization cycle counter; user clock ignored before this state
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || state != ST_INIT) begin
         init_cnt <= 9'h000;
      end else if (init_tick) begin
         init_cnt <= init_cnt + 9'h001;
      end
   end

   // Error hold-off counter
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || state != ST_ERROR) begin
         err_cnt <= '0;
      end else if (err_cnt != ERR_LAST) begin
         err_cnt <= err_cnt + EW'(1);
      end
   end

   // Frame walk: wait for sync, option byte, payload, check byte
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || state != ST_LOAD) begin
         byte_idx <= '0;
         chk      <= 8'h00;
      end else if (byte_evt) begin
         if (byte_idx == '0) begin
            if (link.byte_data == SYNC_BYTE) begin
               byte_idx <= IW'(1);
            end
         end else if (byte_idx != BYTE_LAST) begin
            chk      <= chk ^ link.byte_data;
            byte_idx <= byte_idx + IW'(1);
         end
      end
   end

   // Option bits from the first frame byte after sync
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         opt_init_done <= 1'b0;
         opt_user_clk  <= 1'b0;
         opt_auto_rst  <= AUTO_RST_DEF;
      end else if (state == ST_ARM) begin
         opt_init_done <= 1'b0;
         opt_user_clk  <= 1'b0;
      end else if (byte_evt && byte_idx == IW'(1)) begin
         opt_init_done <= link.byte_data[OPT_INIT_DONE_BIT];
         opt_user_clk  <= link.byte_data[OPT_USER_CLK_BIT];
         opt_auto_rst  <= link.byte_data[OPT_AUTO_RESTART_BIT];
      end
   end

   // Next state; request low wins from every state
   always_comb begin
      next_state = state;
      case (state)
         ST_RESET: begin
            if (req_s) begin
               next_state = ST_ARM;
            end
         end
         ST_ARM: begin
            if (!req_s) begin
               next_state = ST_RESET;
            end else if (status_s) begin
               next_state = ST_LOAD;
            end
         end
         ST_LOAD: begin
            if (!req_s) begin
               next_state = ST_RESET;
            end else if (!status_s) begin
               next_state = ST_ERROR;
            end else if (byte_evt && byte_idx == BYTE_LAST) begin
               next_state = chk_ok ? ST_WAIT_DONE : ST_ERROR;
            end
         end
         ST_WAIT_DONE: begin
            if (!req_s) begin
               next_state = ST_RESET;
            end else if (!status_s) begin
               next_state = ST_ERROR;
            end else if (done_s) begin
               next_state = ST_INIT;
            end
         end
         ST_INIT: begin
            if (!req_s) begin
               next_state = ST_RESET;
            end else if (!status_s) begin
               next_state = ST_ERROR;
            end else if (init_tick && init_cnt == INIT_LAST) begin
               next_state = ST_USER;
            end
         end
         ST_USER: begin
            if (!req_s) begin
               next_state = ST_RESET;
            end
         end
         ST_ERROR: begin
            if (!req_s) begin
               next_state = ST_RESET;
            end else if (opt_auto_rst && err_cnt == ERR_LAST) begin
               next_state = ST_ARM;
            end
         end
         default: begin
            next_state = ST_RESET;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         state <= ST_RESET;
      end else begin
         state <= next_state;
      end
   end

   // Open-drain pins only ever drive low
   always_ff @(posedge clk_i) begin
      drive_low <= 1'b0;
   end

   assign status_n_o  = drive_low;
   assign conf_done_o = drive_low;
   assign init_done_o = drive_low;

   // Status and configuration-complete drivers follow the next state
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         status_n_oe_o  <= 1'b1;
         conf_done_oe_o <= 1'b1;
      end else begin
         status_n_oe_o  <= (next_state == ST_RESET) ||
                           (next_state == ST_ERROR);
         conf_done_oe_o <= (next_state == ST_RESET) ||
                           (next_state == ST_ARM)   ||
                           (next_state == ST_LOAD)  ||
                           (next_state == ST_ERROR);
      end
   end

   // Init-complete held low from its enable until user mode
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         init_done_oe_o <= 1'b0;
      end else begin
         init_done_oe_o <= opt_init_done &&
                           ((next_state == ST_LOAD) ||
                            (next_state == ST_WAIT_DONE) ||
                            (next_state == ST_INIT));
      end
   end

   // User pins floating with pull-ups until user mode
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         io_hiz_o    <= 1'b1;
         io_pullup_o <= 1'b1;
         user_mode_o <= 1'b0;
      end else begin
         io_hiz_o    <= (next_state != ST_USER);
         io_pullup_o <= (next_state != ST_USER);
         user_mode_o <= (next_state == ST_USER);
      end
   end
endmodule

// ### pkg/scl_pkg.sv
// Constants and types of the serial configuration end-of-load controller
package scl_pkg;
   // System clock and internal initialization oscillator
   localparam int CLK_MHZ      = 200;
   localparam int OSC_MHZ      = 10;
   localparam int OSC_DIV      = CLK_MHZ / OSC_MHZ;
   localparam int INIT_CYCLES  = 299;
   // Error hold-off: longest time, rounded down to whole cycles
   localparam int ERR_HOLD_US  = 40;
   localparam int ERR_HOLD_CYC = ERR_HOLD_US * CLK_MHZ;
   // Frame layout: sync byte, option byte, payload, xor check byte
   localparam int          FRAME_BYTES = 16;
   localparam logic [7:0]  SYNC_BYTE   = 8'ha5;
   localparam logic [3:0]  BYTE_BITS   = 4'h8;
   // Option byte field positions
   localparam int OPT_INIT_DONE_BIT    = 0;
   localparam int OPT_USER_CLK_BIT     = 1;
   localparam int OPT_AUTO_RESTART_BIT = 2;

   typedef enum logic [2:0] {
      ST_RESET     = 3'b000,
      ST_ARM       = 3'b001,
      ST_LOAD      = 3'b010,
      ST_WAIT_DONE = 3'b011,
      ST_INIT      = 3'b100,
      ST_USER      = 3'b101,
      ST_ERROR     = 3'b110
   } scl_state_t;
endpackage

// ### pkg/scl_link_if.sv
// Received configuration bytes passed from the shift clock domain
interface scl_link_if;
   logic [7:0] byte_data;
   logic       byte_tgl;

   modport rx   (output byte_data, output byte_tgl);
   modport core (input byte_data, input byte_tgl);
endinterface

// ### src/scl_sync.sv
// Three-stage synchroniser that accepts a change once stages two and three agree
module scl_sync
   import scl_pkg::*;
#(
   parameter logic INIT = 1'b0
) (
   input  wire logic clk_i,
   input  wire logic sys_rst_i,
   input  wire logic async_i,
   output logic      sync_o
);
   logic ff1;
   logic ff2;
   logic ff3;

   // Shift chain; the first stage feeds only the second
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         ff1 <= INIT;
         ff2 <= INIT;
         ff3 <= INIT;
      end else begin
         ff1 <= async_i;
         ff2 <= ff1;
         ff3 <= ff2;
      end
   end

   // Filtered level follows only agreeing stages
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         sync_o <= INIT;
      end else if (ff2 == ff3) begin
         sync_o <= ff3;
      end
   end
endmodule

// ### src/scl_link_rx.sv
// Shift clock domain receiver: start-bit framed bytes, MSB first
module scl_link_rx
   import scl_pkg::*;
(
   input  wire logic   shift_clk_i,
   input  wire logic   sys_rst_i,
   input  wire logic   serial_config_data_i,
   scl_link_if.rx      link
);
   logic       rst_ff1;
   logic       rst_ff2;
   logic [3:0] bit_cnt;
   logic [6:0] shreg;

   // Reset raised at once, since the shift clock is stopped during reset,
   // and lowered only after two shift clock edges
   always_ff @(posedge shift_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rst_ff1 <= 1'b1;
         rst_ff2 <= 1'b1;
      end else begin
         rst_ff1 <= 1'b0;
         rst_ff2 <= rst_ff1;
      end
   end

   // Hunt for a zero start bit, then gather eight bits; idle line is high
   always_ff @(posedge shift_clk_i) begin
      if (rst_ff2) begin
         bit_cnt        <= 4'h0;
         shreg          <= 7'h00;
         link.byte_data <= 8'h00;
         link.byte_tgl  <= 1'b0;
      end else if (bit_cnt == 4'h0) begin
         if (!serial_config_data_i) begin
            bit_cnt <= 4'h1;
         end
      end else if (bit_cnt == BYTE_BITS) begin
         link.byte_data <= {shreg, serial_config_data_i};
         link.byte_tgl  <= ~link.byte_tgl;
         bit_cnt        <= 4'h0;
      end else begin
         shreg   <= {shreg[5:0], serial_config_data_i};
         bit_cnt <= bit_cnt + 4'h1;
      end
   end
endmodule

// ### verification/scl_cfg_ctrl_asserts.sv
// Port assertions of the configuration end-of-load controller
module scl_cfg_ctrl_asserts
   import scl_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic cfg_req_n_i,
   input wire logic status_n_i,
   input wire logic conf_done_i,
   input wire logic user_clk_i,
   input wire logic status_n_o,
   input wire logic status_n_oe_o,
   input wire logic conf_done_o,
   input wire logic conf_done_oe_o,
   input wire logic init_done_o,
   input wire logic init_done_oe_o,
   input wire logic io_hiz_o,
   input wire logic io_pullup_o,
   input wire logic user_mode_o
);
   timeunit 1ns;
   timeprecision 100ps;
   int   cd_cnt;
   int   uc_cnt;
   logic uclk_q;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   // Cycles and user clock edges since the shared done line rose
   always_ff @(posedge clk_i) begin
      uclk_q <= user_clk_i;
      if (!conf_done_i) begin
         cd_cnt <= 0;
         uc_cnt <= 0;
      end else begin
         cd_cnt <= cd_cnt + 1;
         uc_cnt <= uc_cnt + int'(user_clk_i && !uclk_q);
      end
   end
   property p_req_low;
      !cfg_req_n_i [*8] |-> status_n_oe_o && conf_done_oe_o && io_hiz_o;
   endproperty
   a_req_low: assert property (p_req_low)
      else $error("request low without reset outputs");
   property p_user_excl;
      user_mode_o |-> !io_hiz_o && !status_n_oe_o && !conf_done_oe_o
         && !init_done_oe_o;
   endproperty
   a_user_excl: assert property (p_user_excl)
      else $error("user mode with configuration outputs active");
   property p_user_done;
      user_mode_o |-> conf_done_i;
   endproperty
   a_user_done: assert property (p_user_done)
      else $error("user mode while done line low");
   property p_user_entry;
      $rose(user_mode_o) |-> uc_cnt >= INIT_CYCLES
         || cd_cnt >= INIT_CYCLES * OSC_DIV - OSC_DIV;
   endproperty
   a_user_entry: assert property (p_user_entry)
      else $error("user mode entered too early");
   property p_release;
      $fell(status_n_oe_o) |-> cfg_req_n_i && $past(cfg_req_n_i, 2);
   endproperty
   a_release: assert property (p_release)
      else $error("status released while request low");
   property p_load_status;
      $fell(conf_done_oe_o) |-> status_n_i && cfg_req_n_i;
   endproperty
   a_load_status: assert property (p_load_status)
      else $error("load finished without status released");
   property p_status_low;
      !status_n_i [*8] |-> !user_mode_o;
   endproperty
   a_status_low: assert property (p_status_low)
      else $error("user mode while status held low");
   property p_err_hold;
      $rose(status_n_oe_o) |=> status_n_oe_o [*8];
   endproperty
   a_err_hold: assert property (p_err_hold)
      else $error("status pull dropped too soon");
   property p_od;
      !status_n_o && !conf_done_o && !init_done_o;
   endproperty
   a_od: assert property (p_od)
      else $error("open drain value not low");
   property p_pull;
      io_hiz_o == io_pullup_o;
   endproperty
   a_pull: assert property (p_pull)
      else $error("pull-ups differ from float state");
   c_user: cover property ($rose(user_mode_o));
   c_err: cover property ($rose(status_n_oe_o) && cfg_req_n_i);
   c_rel: cover property ($fell(status_n_oe_o));
endmodule

bind scl_cfg_ctrl scl_cfg_ctrl_asserts scl_cfg_ctrl_asserts_i (
   .clk_i, .sys_rst_i, .cfg_req_n_i, .status_n_i, .conf_done_i,
   .user_clk_i, .status_n_o, .status_n_oe_o, .conf_done_o,
   .conf_done_oe_o, .init_done_o, .init_done_oe_o, .io_hiz_o,
   .io_pullup_o, .user_mode_o);

// ### verification/scl_src_model.sv
// Serial configuration source: shift clock, data and status pull
module scl_src_model (
   input  wire logic status_n_i,
   input  wire logic conf_done_i,
   output logic      shift_clk_o,
   output logic      data_o,
   output logic      oe_pull_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // Clock rests low and data high outside frames
   initial begin
      shift_clk_o = 1'b0;
      data_o = 1'b1;
      oe_pull_o = 1'b0;
   end
   // One bit, set up while the clock is low
   task automatic bit_out(input logic b);
      data_o = b;
      #40 shift_clk_o = 1'b1;
      #40 shift_clk_o = 1'b0;
   endtask
   task automatic byte_out(input logic [7:0] v);
      bit_out(1'b0);
      for (int i = 7; i >= 0; i--) bit_out(v[i]);
   endtask
   // Whole frame once status is high, then the done wait
   task automatic send(input logic [7:0] opt, input logic bad);
      int w;
      w = 0;
      while ((!status_n_i || conf_done_i) && w < 4000) begin
         #10;
         w++;
      end
      repeat (12) bit_out(1'b1);
      byte_out(8'ha5);
      byte_out(opt);
      byte_out(8'h3c);
      byte_out(opt ^ 8'h3c ^ {7'h00, bad});
      w = 0;
      // A low status or a high done line ends the wait
      while (!conf_done_i && status_n_i && w < 64) begin
         bit_out(1'b1);
         w++;
      end
      if (w == 64) begin
         oe_pull_o = 1'b1;
         #400 oe_pull_o = 1'b0;
      end
   endtask
endmodule

// ### verification/tb.sv
// Self-checking bench of the configuration end-of-load controller
`define CHK(nm, e, g) begin \
   checks_done++; \
   if ((g) !== (e)) begin \
      n_mismatch++; \
      $display("mismatch %s exp %0h got %0h", nm, e, g); \
   end \
end
module tb;
   import scl_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int HOLD = 50;
   localparam int TINIT = INIT_CYCLES * OSC_DIV;
   localparam int TLO = TINIT - OSC_DIV;
   localparam int THI = TINIT + OSC_DIV;
   int   n_mismatch = 0;
   int   checks_done = 0;
   int   n;
   logic clk, rst, req_n, uclk, cd_hold;
   logic st_o, st_oe, cd_o, cd_oe, id_o, id_oe, hiz, pull, umode;
   logic sclk, sdat, src_pull;
   // Wired lines with pull-ups
   wire logic status_n = !(st_oe || src_pull);
   wire logic conf_done = !(cd_oe || cd_hold);

   scl_cfg_ctrl #(.ERR_HOLD_CYCLES(HOLD), .N_BYTES(4)) scl_cfg_ctrl_i (
      .clk_i(clk), .sys_rst_i(rst), .shift_clk_i(sclk),
      .serial_config_data_i(sdat), .cfg_req_n_i(req_n),
      .status_n_i(status_n), .status_n_o(st_o), .status_n_oe_o(st_oe),
      .conf_done_i(conf_done), .conf_done_o(cd_o), .conf_done_oe_o(cd_oe),
      .init_done_o(id_o), .init_done_oe_o(id_oe), .user_clk_i(uclk),
      .io_hiz_o(hiz), .io_pullup_o(pull), .user_mode_o(umode));
   scl_src_model src_i (.status_n_i(status_n), .conf_done_i(conf_done),
      .shift_clk_o(sclk), .data_o(sdat), .oe_pull_o(src_pull));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   function automatic logic pick(input int s);
      case (s)
         0: return st_oe;
         1: return cd_oe;
         2: return umode;
         default: return conf_done;
      endcase
   endfunction
   // Bounded wait for a level, counting cycles
   task automatic wt(input int s, input logic v, input int lim);
      n = 0;
      while (pick(s) !== v && n < lim) begin
         @(negedge clk);
         n++;
      end
      if (pick(s) !== v) begin
         n_mismatch++;
         $display("mismatch wait_%0d exp %0b got %0b", s, v, pick(s));
         summarize();
      end
   endtask
   task automatic pulses(input int k);
      repeat (k) begin
         @(posedge clk) uclk <= 1'b1;
         repeat (4) @(posedge clk);
         uclk <= 1'b0;
         repeat (3) @(posedge clk);
      end
   endtask
   // Bad check byte without auto-restart: status stays pulled
   task automatic t_bad_manual();
      fork
         src_i.send(8'h00, 1'b1);
         wt(0, 1'b1, 3000);
      join
      repeat (200) @(negedge clk);
      `CHK("status_oe", 1'b1, st_oe)
      `CHK("io_hiz", 1'b1, hiz)
      $display("done bad_manual");
   endtask
   // Request pulse of 2 us, then status release
   task automatic t_reconf();
      @(posedge clk) req_n <= 1'b0;
      repeat (12) @(negedge clk);
      `CHK("status_oe", 1'b1, st_oe)
      `CHK("conf_done_oe", 1'b1, cd_oe)
      `CHK("io_hiz", 1'b1, hiz)
      `CHK("user_mode", 1'b0, umode)
      repeat (400) @(posedge clk);
      req_n <= 1'b1;
      wt(0, 1'b0, 40);
      `CHK("release_late", 1'b1, n > 2)
      $display("done reconf");
   endtask
   // Oscillator start-up held back by another device on the done line
   task automatic t_osc();
      `CHK("init_done_oe", 1'b0, id_oe)
      @(posedge clk) cd_hold <= 1'b1;
      fork
         src_i.send(8'h05, 1'b0);
         begin
            wt(1, 1'b0, 3000);
            repeat (100) @(negedge clk);
            `CHK("init_done_oe", 1'b1, id_oe)
            `CHK("user_mode", 1'b0, umode)
            @(posedge clk) cd_hold <= 1'b0;
            wt(2, 1'b1, 7000);
            `CHK("osc_init", 1'b1, n >= TLO && n <= THI)
         end
      join
      `CHK("init_done_oe", 1'b0, id_oe)
      `CHK("io_hiz", 1'b0, hiz)
      `CHK("io_pullup", 1'b0, pull)
      $display("done osc");
   endtask
   // Bad check byte with auto-restart: timed release
   task automatic t_auto();
      fork
         src_i.send(8'h04, 1'b1);
         begin
            wt(0, 1'b1, 3000);
            wt(0, 1'b0, 4 * HOLD);
            `CHK("hold", 1'b1, n >= HOLD - 2 && n <= HOLD + 1)
         end
      join
      $display("done auto");
   endtask
   // User start-up clock: ignored in loading, counted in initialization
   task automatic t_user();
      fork
         src_i.send(8'h06, 1'b0);
         pulses(40);
      join
      wt(3, 1'b1, 3000);
      repeat (1000) @(negedge clk);
      `CHK("user_mode", 1'b0, umode)
      pulses(INIT_CYCLES - 1);
      repeat (12) @(negedge clk);
      `CHK("user_mode", 1'b0, umode)
      pulses(1);
      wt(2, 1'b1, 16);
      `CHK("user_mode", 1'b1, umode)
      `CHK("init_done_oe", 1'b0, id_oe)
      $display("done user");
   endtask
   initial begin
      rst = 1'b1;
      req_n = 1'b1;
      uclk = 1'b0;
      cd_hold = 1'b0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      `CHK("init_done_oe", 1'b0, id_oe)
      `CHK("io_pullup", 1'b1, pull)
      wt(0, 1'b0, 40);
      t_bad_manual();
      t_reconf();
      t_osc();
      t_reconf();
      t_auto();
      t_user();
      summarize();
   end
endmodule
